/* File: tb/oled_display_command_decoder_test.sv */
// self-checking bench for the display command decoder
module oled_display_command_decoder_test
    import oledcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock;
    logic        rst;
    logic        wr_valid;
    logic        wr_ready;
    logic        wr_cmd_data_select;
    logic [7:0]  wr_data;
    logic        rd_req;
    logic        rd_cmd_data_select;
    logic        rd_serial;
    logic        rd_valid;
    logic [7:0]  rd_data;
    oledcd_cfg_t cfg;
    logic [7:0]  column;
    logic [2:0]  page;
    logic        rmw_active;
    logic        busy;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          pend = 0;
    oledcd_cfg_t exp_cfg;
    logic [7:0]  exp_col;
    logic [7:0]  saved_col;
    logic        got;
    logic [7:0]  rdv;
    logic [7:0]  tbl [22] = '{8'h12, 8'h05, 8'h33, 8'h7F, 8'h81, 8'hA8,
        8'hA8, 8'h00, 8'hAD, 8'h8A, 8'hAD, 8'h00, 8'hA1, 8'hA5, 8'hA7,
        8'hE3, 8'hAF, 8'h30, 8'hA0, 8'hA4, 8'hA6, 8'h40};
    logic [7:0]  dat [3] = '{8'h5A, 8'hC3, 8'h96};

    oledcd_decoder #(.COLS(132), .PAGES(8)) DUT (.clock(clock), .rst(rst),
        .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_cmd_data_select(wr_cmd_data_select), .wr_data(wr_data),
        .rd_req(rd_req), .rd_cmd_data_select(rd_cmd_data_select),
        .rd_serial(rd_serial), .rd_valid(rd_valid), .rd_data(rd_data),
        .cfg(cfg), .column(column), .page(page), .rmw_active(rmw_active),
        .busy(busy));

    oledcd_host host (.clock(clock), .wr_valid(wr_valid),
        .wr_cmd_data_select(wr_cmd_data_select), .wr_data(wr_data),
        .rd_req(rd_req), .rd_cmd_data_select(rd_cmd_data_select),
        .rd_serial(rd_serial), .rd_valid(rd_valid), .rd_data(rd_data));

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        checks_done++;
        if (seen !== expv)
        begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // reference decoding of one command byte
    task automatic apply(input logic [7:0] b);
        if (pend == 1)
            exp_cfg.contrast = b;
        else if (pend == 2)
            exp_cfg.mux_ratio = b[5:0];
        else if (pend == 3 && b[7:1] == 7'h45)
            exp_cfg.dcdc_on = b[0];
        else if (pend == 0)
            casez (b)
                8'b0000_????: exp_col[3:0] = b[3:0];
                8'b0001_????: exp_col[7:4] = b[3:0];
                8'b0011_00??: exp_cfg.pump_sel = b[1:0];
                8'b01??_????: exp_cfg.start_line = b[5:0];
                8'b1010_000?: exp_cfg.seg_remap = b[0];
                8'b1010_010?: exp_cfg.entire_on = b[0];
                8'b1010_011?: exp_cfg.reverse = b[0];
                8'b1010_111?: exp_cfg.display_on = b[0];
                8'hE0: saved_col = exp_col;
                8'hEE: exp_col = saved_col;
                default: ;
            endcase
        pend = (pend != 0) ? 0 : (b == 8'h81) ? 1 : (b == 8'hA8) ? 2 :
               (b == 8'hAD) ? 3 : 0;
    endtask

    task automatic cmd(input logic [7:0] b);
        host.wr(1'b0, b);
        apply(b);
        check(32'(cfg[26:13]), 32'(exp_cfg[26:13]));
        check(32'(cfg[12:5]), 32'(exp_cfg[12:5]));
        check(32'(cfg[4:0]), 32'(exp_cfg[4:0]));
        check(32'(column), 32'(exp_col));
    endtask

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    initial
    begin
        rst = 1'b1;
        exp_cfg = '0;
        exp_cfg.contrast = 8'h80;
        exp_cfg.mux_ratio = 6'h3F;
        exp_cfg.pump_sel = 2'h2;
        exp_cfg.dcdc_on = 1'b1;
        exp_col = 8'h00;
        saved_col = 8'h00;
        repeat (5) @(negedge clock);
        check(32'({busy, wr_ready}), 32'h2);
        check(32'(cfg), 32'(exp_cfg));
        check(32'(column), 32'(exp_col));
        rst = 1'b0;
        // bytes sent while busy are rejected and never act
        host.wr(1'b0, 8'h81);
        check(32'({busy, cfg.contrast}), 32'({1'b1, 8'h80}));
        host.wr(1'b0, 8'h55);
        for (int i = 0; i < 40 && busy !== 1'b0; i++)
            @(negedge clock);
        repeat (4) @(negedge clock);
        check(32'({wr_ready, cfg.contrast}), 32'h180);
        host.rd(1'b0, got, rdv);
        check(32'({got, rdv}), 32'h140);
        foreach (tbl[i])
            cmd(tbl[i]);
        host.rd(1'b0, got, rdv);
        check(32'({got, rdv}), 32'h100);
        cmd(8'hB1);
        check(32'(page), 32'd1);
        cmd(8'h10);
        cmd(8'h00);
        foreach (dat[i])
        begin
            host.wr(1'b1, dat[i]);
            check(32'(column), 32'(i + 1));
        end
        cmd(8'h00);
        host.dummy_read();
        foreach (dat[i])
        begin
            host.rd(1'b1, got, rdv);
            check(32'({got, rdv}), 32'({1'b1, dat[i]}));
        end
        cmd(8'h00);
        cmd(8'hE0);
        check(32'(rmw_active), 32'd1);
        host.dummy_read();
        host.rd(1'b1, got, rdv);
        check(32'({got, rdv, column}), 32'({1'b1, 8'h5A, 8'h00}));
        host.wr(1'b1, 8'h11);
        check(32'(column), 32'h01);
        exp_col = 8'h01;
        cmd(8'hEE);
        check(32'(rmw_active), 32'd0);
        host.dummy_read();
        host.rd(1'b1, got, rdv);
        check(32'({got, rdv}), 32'h111);
        // ram reads on the serial link get no answer
        host.set_serial(1'b1);
        host.rd(1'b1, got, rdv);
        check(32'(got), 32'd0);
        host.set_serial(1'b0);
        summarize();
    end
endmodule

/* File: tb/oledcd_host.sv */
// host model driving the decoder's byte and read ports
module oledcd_host
    import oledcd_pkg::*;
(
    input  wire logic       clock,
    output logic            wr_valid,
    output logic            wr_cmd_data_select,
    output logic [7:0]      wr_data,
    output logic            rd_req,
    output logic            rd_cmd_data_select,
    output logic            rd_serial,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        wr_valid = 1'b0;
        wr_cmd_data_select = 1'b0;
        wr_data = 8'h00;
        rd_req = 1'b0;
        rd_cmd_data_select = 1'b0;
        rd_serial = 1'b0;
    end

    // one byte per call; no wait on ready, the buffer holds two
    task automatic wr(input logic sel, input logic [7:0] d);
        @(negedge clock);
        wr_valid = 1'b1;
        wr_cmd_data_select = sel;
        wr_data = d;
        @(negedge clock);
        wr_valid = 1'b0;
        wr_data = ~d; // released bus never shows the last byte
        repeat (4) @(negedge clock); // paced instead of polling busy
    endtask

    // read strobe; answer awaited under a bound, then strobe low 3 cycles
    task automatic rd(input logic sel, output logic got,
                      output logic [7:0] d);
        int n;
        got = 1'b0;
        d = 8'h00;
        @(negedge clock);
        rd_cmd_data_select = sel;
        rd_req = 1'b1;
        for (n = 0; n < 8 && !got; n++)
        begin
            @(negedge clock);
            if (rd_valid === 1'b1)
            begin
                got = 1'b1;
                d = rd_data;
            end
        end
        rd_req = 1'b0;
        repeat (3) @(negedge clock);
    endtask

    // link kind changes only between transfers, off the clock edge
    task automatic set_serial(input logic s);
        @(negedge clock);
        rd_serial = s;
    endtask

    // first ram read after an address change is thrown away
    task automatic dummy_read();
        logic       g;
        logic [7:0] d;
        rd(1'b1, g, d);
    endtask
endmodule

/* File: verilog/oledcd_buf2.sv */
// two-entry valid/ready buffer for incoming bytes
module oledcd_buf2
    import oledcd_pkg::*;
#(
    parameter int W = 9
)(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              rd;
        logic              wr;
        logic [1:0]        cnt;
    } oledcd_bst_t;

    oledcd_bst_t s_r;
    oledcd_bst_t s_nxt;
    logic        push;
    logic        pop;

    assign in_ready  = (s_r.cnt != 2'd2);
    assign out_valid = (s_r.cnt != 2'd0);
    assign out_data  = s_r.mem[s_r.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wr] = in_data;
            s_nxt.wr = ~s_r.wr;
        end
        if (pop)
            s_nxt.rd = ~s_r.rd;
        s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    full_never_over_a: assert property (@(posedge clock) disable iff (rst)
        s_r.cnt <= 2'd2) else $error("buffer count over two");
endmodule

/* File: verilog/oledcd_cfg.svh */
// constants for the display command decoder
`ifndef OLEDCD_CFG_SVH
`define OLEDCD_CFG_SVH
`define OLEDCD_CMD_RMW_START   8'hE0
`define OLEDCD_CMD_RMW_END     8'hEE
`define OLEDCD_CMD_NOP         8'hE3
`define OLEDCD_CMD_CONTRAST    8'h81
`define OLEDCD_CMD_MUX         8'hA8
`define OLEDCD_CMD_DCDC        8'hAD
`define OLEDCD_CMD_DISP_OFF    8'hAE
`define OLEDCD_CMD_PAGE        4'hB
`define OLEDCD_DCDC_PFX        7'h45
`define OLEDCD_POR_COL_LO      4'h0
`define OLEDCD_POR_COL_HI      4'h0
`define OLEDCD_POR_PUMP        2'h2
`define OLEDCD_POR_START       6'h00
`define OLEDCD_POR_CONTRAST    8'h80
`define OLEDCD_POR_MUX         6'h3F
`define OLEDCD_POR_DCDC        1'b1
`define OLEDCD_POR_PAGE        3'h0
`define OLEDCD_BUSY_POR_NS     100
`define OLEDCD_CLK_NS          10
`define OLEDCD_BUSY_POR_CYC    ((`OLEDCD_BUSY_POR_NS + `OLEDCD_CLK_NS - 1) \
                               / `OLEDCD_CLK_NS)
`define OLEDCD_ST_BUSY_BIT     7
`define OLEDCD_ST_OFF_BIT      6
`endif

/* File: verilog/oledcd_decoder.sv */
// command and data decoder of the dot-matrix display controller
// Notes on behaviour
// (R01) end command restores saved column, leaves rmw
// (R02) rmw: reads hold column, writes advance
// (R03) data write stores byte, column plus one
// (R04) status read: busy d7, off d6, low zero
// (R05) busy during reset work; commands rejected
// (R06) host may skip polling if paced
// (R07) off flag inverse of display on bit
// (R08) data read returns ram byte at page/column
// (R09) host discards one dummy read after address
// (R10) no ram reads over serial interface
// (R11) 0000xxxx loads low column nibble
// (R12) 0001xxxx loads high column nibble
// (R13) 001100xx sets pump voltage select
// (R14) 01xxxxxx sets first displayed ram line
// (R15) 81h then byte sets contrast
// (R16) 1010000x selects segment remap
// (R17) 1010010x forces entire display on
// (R18) 1010011x selects reversed polarity
// (R19) a8h then byte sets multiplex ratio
// (R20) adh then 1000101x sets dc-dc enable
// (R21) select low is command, high data
// (R22) e3h does nothing
// (R23) byte after two-byte opener is its argument
`include "oledcd_cfg.svh"
module oledcd_decoder
    import oledcd_pkg::*;
#(
    parameter int COLS = 132,
    parameter int PAGES = 8
)(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        wr_valid,
    output logic             wr_ready,
    input  wire logic        wr_cmd_data_select,
    input  wire logic [7:0]  wr_data,
    input  wire logic        rd_req,
    input  wire logic        rd_cmd_data_select,
    input  wire logic        rd_serial,
    output logic             rd_valid,
    output logic [7:0]       rd_data,
    output oledcd_cfg_t      cfg,
    output logic [7:0]       column,
    output logic [2:0]       page,
    output logic             rmw_active,
    output logic             busy
);
    typedef struct packed {
        oledcd_cfg_t cfg;
        logic [7:0]  col;
        logic [7:0]  col_saved;
        logic [2:0]  page;
        logic        rmw;
        oledcd_arg_t arg;
        logic [7:0]  rd_latch;
        logic [7:0]  rd_data;
        logic        rd_valid;
        logic        busy;
        logic [7:0]  busy_cnt;
        logic        wr_ready;
    } oledcd_st_t;

    localparam int CW = 8;
    localparam logic [7:0] BUSY_CYC = 8'(`OLEDCD_BUSY_POR_CYC);

    oledcd_st_t   s_r;
    oledcd_st_t   s_nxt;
    logic [7:0]   ram [PAGES*COLS];
    logic         ram_we;
    logic [10:0]  ram_addr;
    logic         b_valid;
    logic         b_ready;
    oledcd_byte_t b_data;
    oledcd_byte_t in_byte;
    logic         rd_sync1_r;
    logic         rd_sync2_r;
    logic         rd_prev_r;
    logic         rd_pulse;
    logic         take;
    logic         cmd_take;
    logic         sel_sync1_r;
    logic         sel_sync2_r;
    logic         ser_sync1_r;
    logic         ser_sync2_r;

    assign in_byte.cmd_data_select = wr_cmd_data_select;
    assign in_byte.data            = wr_data;

    // bytes queue here; while busy the input is gated off, so bytes offered then are dropped
    oledcd_buf2 #(
        .W ($bits(oledcd_byte_t))
    ) u_buf (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (wr_valid && !s_r.busy), // [R05]
        .in_ready  (),
        .in_data   (in_byte),
        .out_valid (b_valid),
        .out_ready (b_ready),
        .out_data  (b_data)
    );

    // read strobe comes from the pins, so it is synchronised first
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rd_sync1_r  <= 1'b0;
            rd_sync2_r  <= 1'b0;
            rd_prev_r   <= 1'b0;
            sel_sync1_r <= 1'b0;
            sel_sync2_r <= 1'b0;
            ser_sync1_r <= 1'b0;
            ser_sync2_r <= 1'b0;
        end
        else
        begin
            rd_sync1_r  <= rd_req;
            rd_sync2_r  <= rd_sync1_r;
            rd_prev_r   <= rd_sync2_r;
            // select pins take the same two stages, so they line up
            sel_sync1_r <= rd_cmd_data_select;
            sel_sync2_r <= sel_sync1_r;
            ser_sync1_r <= rd_serial;
            ser_sync2_r <= ser_sync1_r;
        end
    end
    assign rd_pulse = rd_sync2_r && !rd_prev_r;

    // while busy the buffer's output is held, so nothing queued is taken
    assign b_ready = !s_r.busy; // [R05]
    assign take    = b_valid && b_ready;
    assign cmd_take = take && !b_data.cmd_data_select
                      && s_r.arg == OLEDCD_ARG_NONE;
    assign ram_addr = 11'(s_r.page * COLS) + 11'(s_r.col);
    assign ram_we   = take && b_data.cmd_data_select // [R21]
                      && (s_r.col < CW'(COLS));

    always_ff @(posedge clock)
    begin
        if (ram_we)
            ram[ram_addr] <= b_data.data; // [R03]
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rd_valid = 1'b0;
        s_nxt.wr_ready = 1'b1;
        if (s_r.busy)
        begin
            s_nxt.wr_ready = 1'b0;
            s_nxt.busy_cnt = s_r.busy_cnt - 8'd1;
            if (s_r.busy_cnt == 8'd1)
                s_nxt.busy = 1'b0;
        end
        if (take && b_data.cmd_data_select)
            s_nxt.col = s_r.col + 8'd1; // [R03] [R02]
        else if (take && s_r.arg != OLEDCD_ARG_NONE)
        begin
            // second command byte lands as an argument; a data byte is written as data [R23]
            s_nxt.arg = OLEDCD_ARG_NONE;
            case (s_r.arg)
                OLEDCD_ARG_CONTRAST: s_nxt.cfg.contrast = b_data.data; // [R15]
                OLEDCD_ARG_MUX:
                    s_nxt.cfg.mux_ratio = b_data.data[5:0]; // [R19]
                OLEDCD_ARG_DCDC:
                begin
                    if (b_data.data[7:1] == `OLEDCD_DCDC_PFX)
                        s_nxt.cfg.dcdc_on = b_data.data[0]; // [R20]
                end
                default: s_nxt.arg = OLEDCD_ARG_NONE;
            endcase
        end
        else if (take)
        begin
            casez (b_data.data) // [R21]
                8'b0000_????: s_nxt.col[3:0] = b_data.data[3:0]; // [R11]
                8'b0001_????: s_nxt.col[7:4] = b_data.data[3:0]; // [R12]
                8'b0011_00??: s_nxt.cfg.pump_sel = b_data.data[1:0]; // [R13]
                8'b01??_????: s_nxt.cfg.start_line = b_data.data[5:0]; // [R14]
                `OLEDCD_CMD_CONTRAST: s_nxt.arg = OLEDCD_ARG_CONTRAST; // [R15]
                8'b1010_000?: s_nxt.cfg.seg_remap = b_data.data[0]; // [R16]
                8'b1010_010?: s_nxt.cfg.entire_on = b_data.data[0]; // [R17]
                8'b1010_011?: s_nxt.cfg.reverse = b_data.data[0]; // [R18]
                `OLEDCD_CMD_MUX: s_nxt.arg = OLEDCD_ARG_MUX; // [R19]
                `OLEDCD_CMD_DCDC: s_nxt.arg = OLEDCD_ARG_DCDC; // [R20]
                8'b1010_111?: s_nxt.cfg.display_on = b_data.data[0];
                8'b1011_????: s_nxt.page = b_data.data[2:0];
                `OLEDCD_CMD_RMW_START:
                begin
                    s_nxt.rmw       = 1'b1;
                    s_nxt.col_saved = s_r.col;
                end
                `OLEDCD_CMD_RMW_END:
                begin
                    s_nxt.rmw = 1'b0; // [R01]
                    if (s_r.rmw)
                        s_nxt.col = s_r.col_saved; // [R01]
                end
                `OLEDCD_CMD_NOP: s_nxt.arg = OLEDCD_ARG_NONE; // [R22]
                default: s_nxt.arg = OLEDCD_ARG_NONE;
            endcase
        end
        if (rd_pulse)
        begin
            s_nxt.rd_valid = 1'b1;
            if (!sel_sync2_r)
            begin
                s_nxt.rd_data = 8'h00; // [R04]
                s_nxt.rd_data[`OLEDCD_ST_BUSY_BIT] = s_r.busy; // [R04]
                s_nxt.rd_data[`OLEDCD_ST_OFF_BIT] =
                    !s_r.cfg.display_on; // [R07]
            end
            else if (ser_sync2_r)
                s_nxt.rd_valid = 1'b0; // [R10]
            else
            begin
                // pipelined latch: first read after an address is stale
                s_nxt.rd_data  = s_r.rd_latch; // [R08] [R09]
                s_nxt.rd_latch = (s_r.col < CW'(COLS)) ? ram[ram_addr]
                                                       : 8'h00; // [R08]
                if (!s_r.rmw && !(take && b_data.cmd_data_select))
                    s_nxt.col = s_r.col + 8'd1; // [R02]
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.cfg.contrast   <= `OLEDCD_POR_CONTRAST;
            s_r.cfg.mux_ratio  <= `OLEDCD_POR_MUX;
            s_r.cfg.start_line <= `OLEDCD_POR_START;
            s_r.cfg.pump_sel   <= `OLEDCD_POR_PUMP;
            s_r.cfg.dcdc_on    <= `OLEDCD_POR_DCDC;
            s_r.col            <= {`OLEDCD_POR_COL_HI, `OLEDCD_POR_COL_LO};
            s_r.page           <= `OLEDCD_POR_PAGE;
            s_r.arg            <= OLEDCD_ARG_NONE;
            s_r.busy           <= 1'b1; // [R05]
            s_r.busy_cnt       <= BUSY_CYC;
        end
        else
            s_r <= s_nxt;
    end

    assign wr_ready   = s_r.wr_ready;
    assign rd_valid   = s_r.rd_valid;
    assign rd_data    = s_r.rd_data;
    assign cfg        = s_r.cfg;
    assign column     = s_r.col;
    assign page       = s_r.page;
    assign rmw_active = s_r.rmw;
    assign busy       = s_r.busy;

    col_step_a: assert property (@(posedge clock) disable iff (rst) // [R03]
        (take && b_data.cmd_data_select) |=> column == $past(column) + 8'd1)
        else $error("column did not advance after data write");

    rmw_restore_a: assert property (@(posedge clock) disable iff (rst) // [R01]
        (take && !b_data.cmd_data_select && s_r.arg == OLEDCD_ARG_NONE
         && b_data.data == `OLEDCD_CMD_RMW_END && rmw_active)
        |=> !rmw_active && column == $past(s_r.col_saved))
        else $error("end did not restore column");

    rmw_hold_a: assert property (@(posedge clock) disable iff (rst) // [R02]
        (rmw_active && rd_pulse && sel_sync2_r && !take)
        |=> column == $past(column))
        else $error("column moved on read in rmw");

    status_fmt_a: assert property (@(posedge clock) disable iff (rst) // [R04]
        (rd_pulse && !sel_sync2_r) |=> rd_valid
        && rd_data[2:0] == 3'b000 && rd_data[7] == $past(busy)
        && rd_data[6] == !$past(cfg.display_on))
        else $error("status byte wrong");

    busy_block_a: assert property (@(posedge clock) disable iff (rst) // [R05]
        busy |=> $stable(cfg) && $stable(rmw_active) && $stable(page))
        else $error("state changed while busy");

    serial_read_a: assert property (@(posedge clock) disable iff (rst) // [R10]
        (rd_pulse && sel_sync2_r && ser_sync2_r) |=> !rd_valid)
        else $error("serial ram read answered");

    contrast_in_a: assert property (@(posedge clock) disable iff (rst) // [R15]
        (take && !b_data.cmd_data_select && s_r.arg == OLEDCD_ARG_CONTRAST)
        |=> cfg.contrast == $past(b_data.data))
        else $error("contrast argument not stored");

    lo_nibble_a: assert property (@(posedge clock) disable iff (rst) // [R11]
        (take && !b_data.cmd_data_select && s_r.arg == OLEDCD_ARG_NONE
         && b_data.data[7:4] == 4'h0)
        |=> column[3:0] == $past(b_data.data[3:0]))
        else $error("low column nibble not loaded");

    nop_keep_a: assert property (@(posedge clock) disable iff (rst) // [R22]
        (take && !b_data.cmd_data_select && s_r.arg == OLEDCD_ARG_NONE
         && b_data.data == `OLEDCD_CMD_NOP && !rd_pulse)
        |=> $stable(column) && $stable(cfg) && $stable(rmw_active))
        else $error("nop changed state");

    hi_nibble_a: assert property (@(posedge clock) disable iff (rst) // [R12]
        (cmd_take && b_data.data[7:4] == 4'h1 && !rd_pulse)
        |=> column[7:4] == $past(b_data.data[3:0]))
        else $error("high column nibble not loaded");

    pump_set_a: assert property (@(posedge clock) disable iff (rst) // [R13]
        (cmd_take && b_data.data[7:2] == 6'h0C)
        |=> cfg.pump_sel == $past(b_data.data[1:0]))
        else $error("pump select not stored");

    start_line_a: assert property (@(posedge clock) disable iff (rst) // [R14]
        (cmd_take && b_data.data[7:6] == 2'h1)
        |=> cfg.start_line == $past(b_data.data[5:0]))
        else $error("start line not stored");

    seg_remap_a: assert property (@(posedge clock) disable iff (rst) // [R16]
        (cmd_take && b_data.data[7:1] == 7'h50)
        |=> cfg.seg_remap == $past(b_data.data[0]))
        else $error("segment remap not stored");

    entire_on_a: assert property (@(posedge clock) disable iff (rst) // [R17]
        (cmd_take && b_data.data[7:1] == 7'h52)
        |=> cfg.entire_on == $past(b_data.data[0]))
        else $error("entire display bit not stored");

    reverse_set_a: assert property (@(posedge clock) disable iff (rst) // [R18]
        (cmd_take && b_data.data[7:1] == 7'h53)
        |=> cfg.reverse == $past(b_data.data[0]))
        else $error("reverse bit not stored");

    mux_arg_a: assert property (@(posedge clock) disable iff (rst) // [R19]
        (take && !b_data.cmd_data_select && s_r.arg == OLEDCD_ARG_MUX)
        |=> cfg.mux_ratio == $past(b_data.data[5:0]))
        else $error("multiplex argument not stored");

    dcdc_arg_a: assert property (@(posedge clock) disable iff (rst) // [R20]
        (take && !b_data.cmd_data_select && s_r.arg == OLEDCD_ARG_DCDC
         && b_data.data[7:1] == `OLEDCD_DCDC_PFX)
        |=> cfg.dcdc_on == $past(b_data.data[0]))
        else $error("converter argument not stored");

    arg_slot_a: assert property (@(posedge clock) disable iff (rst) // [R23]
        (take && !b_data.cmd_data_select && s_r.arg != OLEDCD_ARG_NONE)
        |=> s_r.arg == OLEDCD_ARG_NONE
        && $stable(rmw_active) && $stable(page))
        else $error("argument byte decoded as command");
endmodule

/* File: verilog/oledcd_pkg.sv */
// types for the display command decoder
package oledcd_pkg;
    typedef struct packed {
        logic       cmd_data_select;
        logic [7:0] data;
    } oledcd_byte_t;

    typedef enum logic [1:0] {
        OLEDCD_ARG_NONE,
        OLEDCD_ARG_CONTRAST,
        OLEDCD_ARG_MUX,
        OLEDCD_ARG_DCDC
    } oledcd_arg_t;

    typedef struct packed {
        logic [7:0] contrast;
        logic [5:0] mux_ratio;
        logic [5:0] start_line;
        logic [1:0] pump_sel;
        logic       seg_remap;
        logic       entire_on;
        logic       reverse;
        logic       dcdc_on;
        logic       display_on;
    } oledcd_cfg_t;
endpackage
